// *** rtl/tmr8_timer.sv ***
/*
 * tmr8_timer: 8-bit up/down timer/counter with two compare units,
 * shared prescaler with reset, sync hold mode and external pin clock.
 * Assumes: one system clock, async active-low reset, a register port
 * with one-cycle strobes, read data returned the cycle after the strobe.
 */
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - hold bit keeps written prescaler reset bits
// - clearing hold bit clears both reset bits
// - sync reset bit resets prescaler, self-clears
// - three flags, each with mask bit
// - three-bit clock select picks tick source
// - select zero stops the counter
// - count readable and writable any time
// - count write beats clear or count
// - bottom zero, max ff, top by mode
// - each tick clears, increments or decrements
// - mode field spans control a and b
// - overflow flag set where mode says
// - count compared with both registers always
// - match sets flag on next tick
// - flag clears on service or written one
// - outputs from match, mode and action
// - compare buffering only in pwm modes
// - active register loads buffer value at top
// - cpu reaches buffer or active register
// - select one undivided, selects two to five prescaler taps
// - selects seven/six count pin rise/fall
// - mode zero wraps, overflow at zero
// - mode two clears on compare a
module tmr8_timer
(
   input  wire logic                   clk_sys,
   input  wire logic                   rst_n,
   input  wire tmr8_pkg::tmr8_bus_req_s regReq,
   output var  logic [7:0]             rdData,
   input  wire logic                   externalTimerPin,
   input  wire logic [2:0]             irqServiced,
   output var  logic [2:0]             irqRequest,
   output var  logic                   compareOutputA,
   output var  logic                   compareOutputB,
   output var  logic                   syncPrescalerReset,
   output var  logic                   asyncPrescalerReset
);

   logic [7:0] syncCtrl;
   logic       syncHold;
   logic [7:0] ctrlA;
   logic [7:0] ctrlB;
   logic [7:0] count;
   logic [7:0] cmpA;
   logic [7:0] cmpB;
   logic [7:0] bufA;
   logic [7:0] bufB;
   logic [2:0] irqMask;
   logic [2:0] flags;
   logic       countingDown;
   logic       blockMatch;
   logic [tmr8_pkg::PRE_WIDTH-1:0] prescaler;
   logic       pinMeta;
   logic       pinSync2;
   logic       pinSync3;
   logic       pinLevel;
   logic       pinLevelPrev;

   logic [2:0] waveMode;
   logic [2:0] clockSelect;
   logic       pwmMode;
   logic       fastMode;
   logic       phaseMode;
   logic [7:0] topValue;
   logic       atTop;
   logic       atBottom;
   logic       matchA;
   logic       matchB;
   logic       timerTick;
   logic [7:0] next_count;
   logic       next_countingDown;
   logic       overflowEvent;
   logic       wrHit;
   logic [2:0] setFlags;

   // decode of control fields
   assign waveMode    = {ctrlB[tmr8_pkg::WGM_B2_POS], ctrlA[tmr8_pkg::WGM_B1_POS],
                         ctrlA[tmr8_pkg::WGM_B0_POS]};
   assign clockSelect = ctrlB[tmr8_pkg::CS_HI:0];
   assign syncHold    = syncCtrl[tmr8_pkg::SYNC_HOLD_POS];
   assign fastMode    = (waveMode == tmr8_pkg::WGM_FAST_MAX)
                     || (waveMode == tmr8_pkg::WGM_FAST_OCRA);
   assign phaseMode   = (waveMode == tmr8_pkg::WGM_PHASE_MAX)
                     || (waveMode == tmr8_pkg::WGM_PHASE_OCRA);
   assign pwmMode     = fastMode || phaseMode;
   assign wrHit       = regReq.wrStrobe;

   // top is max or compare a, bottom is zero
   assign topValue = ((waveMode == tmr8_pkg::WGM_CTC)
                   || (waveMode == tmr8_pkg::WGM_PHASE_OCRA)
                   || (waveMode == tmr8_pkg::WGM_FAST_OCRA))
                   ? cmpA : tmr8_pkg::MAX;
   assign atTop    = (count == topValue);
   assign atBottom = (count == tmr8_pkg::BOTTOM);

   // continuous comparators
   assign matchA = (count == cmpA);
   assign matchB = (count == cmpB);

   // tick source selection
   always_comb
   begin
      unique case (clockSelect)
         tmr8_pkg::CS_STOP:    timerTick = 1'b0;
         tmr8_pkg::CS_DIV1:    timerTick = 1'b1;
         tmr8_pkg::CS_DIV8:    timerTick = !syncPrescalerReset
            && ((prescaler & tmr8_pkg::PRE_MASK8) == tmr8_pkg::PRE_MASK8);
         tmr8_pkg::CS_DIV64:   timerTick = !syncPrescalerReset
            && ((prescaler & tmr8_pkg::PRE_MASK64) == tmr8_pkg::PRE_MASK64);
         tmr8_pkg::CS_DIV256:  timerTick = !syncPrescalerReset
            && ((prescaler & tmr8_pkg::PRE_MASK256) == tmr8_pkg::PRE_MASK256);
         tmr8_pkg::CS_DIV1K:   timerTick = !syncPrescalerReset
            && ((prescaler & tmr8_pkg::PRE_MASK1K) == tmr8_pkg::PRE_MASK1K);
         tmr8_pkg::CS_EXTFALL: timerTick = pinLevelPrev && !pinLevel;
         tmr8_pkg::CS_EXTRISE: timerTick = !pinLevelPrev && pinLevel;
      endcase
   end

   // next count and direction per mode
   always_comb
   begin
      next_count        = count;
      next_countingDown = countingDown;
      if (phaseMode)
      begin
         if (!countingDown && atTop)
         begin
            next_countingDown = 1'b1;
            next_count        = count - 8'h01;
         end
         else if (countingDown && atBottom)
         begin
            next_countingDown = 1'b0;
            next_count        = count + 8'h01;
         end
         else if (countingDown)
         begin
            next_count = count - 8'h01;
         end
         else
         begin
            next_count = count + 8'h01;
         end
      end
      else
      begin
         next_countingDown = 1'b0;
         if ((waveMode == tmr8_pkg::WGM_CTC || fastMode) && atTop)
         begin
            next_count = tmr8_pkg::BOTTOM;
         end
         else
         begin
            next_count = count + 8'h01;
         end
      end
   end

   // overflow point depends on mode
   assign overflowEvent = timerTick && ((waveMode == tmr8_pkg::WGM_CTC)
                        ? (count == tmr8_pkg::MAX)
                        : (next_count == tmr8_pkg::BOTTOM && !atBottom));

   // hardware flag set requests
   always_comb
   begin
      setFlags                         = 3'h0;
      setFlags[tmr8_pkg::OVF_POS]      = overflowEvent;
      setFlags[tmr8_pkg::CMPA_POS]     = timerTick && matchA && !blockMatch;
      setFlags[tmr8_pkg::CMPB_POS]     = timerTick && matchB && !blockMatch;
   end

   // sync control: hold bit and prescaler reset bits
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         syncCtrl <= tmr8_pkg::RESET_BYTE;
      end
      else if (wrHit && regReq.addr == tmr8_pkg::ADDR_SYNC_CTRL)
      begin
         syncCtrl <= {regReq.wrData[tmr8_pkg::SYNC_HOLD_POS], 5'h00,
                      regReq.wrData[tmr8_pkg::ASYNC_RST_POS],
                      regReq.wrData[tmr8_pkg::SYNC_RST_POS]};
      end
      else if (!syncHold)
      begin
         syncCtrl[tmr8_pkg::ASYNC_RST_POS] <= 1'b0;
         syncCtrl[tmr8_pkg::SYNC_RST_POS]  <= 1'b0;
      end
   end

   // reset lines out, one flop after the control bits
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         syncPrescalerReset  <= 1'b0;
         asyncPrescalerReset <= 1'b0;
      end
      else
      begin
         syncPrescalerReset  <= syncCtrl[tmr8_pkg::SYNC_RST_POS];
         asyncPrescalerReset <= syncCtrl[tmr8_pkg::ASYNC_RST_POS];
      end
   end

   // free-running shared prescaler
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prescaler <= '0;
      end
      else if (syncPrescalerReset)
      begin
         prescaler <= '0;
      end
      else
      begin
         prescaler <= prescaler + 10'h001;
      end
   end

   // external pin: three flops, level taken when stages two and three agree
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pinMeta      <= 1'b0;
         pinSync2     <= 1'b0;
         pinSync3     <= 1'b0;
         pinLevel     <= 1'b0;
         pinLevelPrev <= 1'b0;
      end
      else
      begin
         pinMeta      <= externalTimerPin;
         pinSync2     <= pinMeta;
         pinSync3     <= pinSync2;
         pinLevelPrev <= pinLevel;
         if (pinSync2 == pinSync3)
         begin
            pinLevel <= pinSync3;
         end
      end
   end

   // control registers a, b and mask
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrlA   <= tmr8_pkg::RESET_BYTE;
         ctrlB   <= tmr8_pkg::RESET_BYTE;
         irqMask <= 3'h0;
      end
      else if (wrHit)
      begin
         if (regReq.addr == tmr8_pkg::ADDR_CTRL_A)
         begin
            ctrlA <= regReq.wrData & 8'hf3;
         end
         if (regReq.addr == tmr8_pkg::ADDR_CTRL_B)
         begin
            ctrlB <= regReq.wrData & 8'h0f;
         end
         if (regReq.addr == tmr8_pkg::ADDR_IRQ_MASK)
         begin
            irqMask <= regReq.wrData[2:0];
         end
      end
   end

   // counter: cpu write wins over tick update
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count        <= tmr8_pkg::BOTTOM;
         countingDown <= 1'b0;
      end
      else if (wrHit && regReq.addr == tmr8_pkg::ADDR_COUNT)
      begin
         count <= regReq.wrData;
      end
      else if (timerTick)
      begin
         count        <= next_count;
         countingDown <= next_countingDown;
      end
   end

   // count write masks the match at the next tick
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         blockMatch <= 1'b0;
      end
      else if (wrHit && regReq.addr == tmr8_pkg::ADDR_COUNT)
      begin
         blockMatch <= 1'b1;
      end
      else if (timerTick)
      begin
         blockMatch <= 1'b0;
      end
   end

   // compare registers with optional buffering
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cmpA <= tmr8_pkg::RESET_BYTE;
         cmpB <= tmr8_pkg::RESET_BYTE;
         bufA <= tmr8_pkg::RESET_BYTE;
         bufB <= tmr8_pkg::RESET_BYTE;
      end
      else
      begin
         if (wrHit && regReq.addr == tmr8_pkg::ADDR_CMP_A)
         begin
            bufA <= regReq.wrData;
         end
         if (wrHit && regReq.addr == tmr8_pkg::ADDR_CMP_B)
         begin
            bufB <= regReq.wrData;
         end
         if (!pwmMode)
         begin
            if (wrHit && regReq.addr == tmr8_pkg::ADDR_CMP_A)
            begin
               cmpA <= regReq.wrData;
            end
            if (wrHit && regReq.addr == tmr8_pkg::ADDR_CMP_B)
            begin
               cmpB <= regReq.wrData;
            end
         end
         else if (timerTick && atTop && !countingDown)
         begin
            cmpA <= bufA;
            cmpB <= bufB;
         end
      end
   end

   // flags: hardware set wins over clear by write-one or service
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flags <= 3'h0;
      end
      else
      begin
         if (wrHit && regReq.addr == tmr8_pkg::ADDR_FLAGS)
         begin
            flags <= (flags & ~regReq.wrData[2:0] & ~irqServiced) | setFlags;
         end
         else
         begin
            flags <= (flags & ~irqServiced) | setFlags;
         end
      end
   end

   // masked interrupt requests
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irqRequest <= 3'h0;
      end
      else
      begin
         irqRequest <= flags & irqMask;
      end
   end

   // waveform generator for both outputs
   function automatic logic waveStep
   (
      input logic       cur,
      input logic [1:0] action,
      input logic       match
   );
      logic result;
      result = cur;
      if (!pwmMode)
      begin
         if (match)
         begin
            unique case (action)
               tmr8_pkg::COM_NONE:   result = cur;
               tmr8_pkg::COM_TOGGLE: result = !cur;
               tmr8_pkg::COM_CLEAR:  result = 1'b0;
               tmr8_pkg::COM_SET:    result = 1'b1;
            endcase
         end
      end
      else if (action[1])
      begin
         if (fastMode && match)
         begin
            result = action[0];
         end
         else if (fastMode && atTop)
         begin
            result = !action[0];
         end
         else if (phaseMode && match)
         begin
            result = countingDown ? !action[0] : action[0];
         end
      end
      return result;
   endfunction

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         compareOutputA <= 1'b0;
         compareOutputB <= 1'b0;
      end
      else if (timerTick)
      begin
         compareOutputA <= waveStep(compareOutputA,
            ctrlA[tmr8_pkg::COM_A_HI:tmr8_pkg::COM_A_LO], matchA && !blockMatch);
         compareOutputB <= waveStep(compareOutputB,
            ctrlA[tmr8_pkg::COM_B_HI:tmr8_pkg::COM_B_LO], matchB && !blockMatch);
      end
   end

   // read port: data valid only in cycle after the strobe
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdData <= 8'h00;
      end
      else if (regReq.rdStrobe)
      begin
         unique case (regReq.addr)
            tmr8_pkg::ADDR_SYNC_CTRL: rdData <= syncCtrl;
            tmr8_pkg::ADDR_CTRL_A:    rdData <= ctrlA;
            tmr8_pkg::ADDR_CTRL_B:    rdData <= ctrlB;
            tmr8_pkg::ADDR_COUNT:     rdData <= count;
            tmr8_pkg::ADDR_CMP_A:     rdData <= pwmMode ? bufA : cmpA;
            tmr8_pkg::ADDR_CMP_B:     rdData <= pwmMode ? bufB : cmpB;
            tmr8_pkg::ADDR_IRQ_MASK:  rdData <= {5'h00, irqMask};
            tmr8_pkg::ADDR_FLAGS:     rdData <= {5'h00, flags};
         endcase
      end
      else
      begin
         rdData <= 8'h00;
      end
   end

endmodule
`default_nettype wire

// *** shared/tmr8_pkg.sv ***
/*
 * tmr8_pkg: register map, field layout, reset values, modes and bus
 * carrier for the 8-bit timer/counter with sync mode.
 * Assumes: included before any design file, used with tmr8_pkg:: prefix.
 */
`default_nettype none
package tmr8_pkg;

   // register index map, one byte each
   localparam logic [2:0] ADDR_SYNC_CTRL = 3'h0;  // general_timer_sync_control
   localparam logic [2:0] ADDR_CTRL_A    = 3'h1;  // timer_control_a
   localparam logic [2:0] ADDR_CTRL_B    = 3'h2;  // timer_control_b
   localparam logic [2:0] ADDR_COUNT     = 3'h3;  // count_register
   localparam logic [2:0] ADDR_CMP_A     = 3'h4;  // compare_register_a
   localparam logic [2:0] ADDR_CMP_B     = 3'h5;  // compare_register_b
   localparam logic [2:0] ADDR_IRQ_MASK  = 3'h6;  // timer_irq_mask_register
   localparam logic [2:0] ADDR_FLAGS     = 3'h7;  // timer_flag_register

   // sync control fields
   localparam int SYNC_HOLD_POS   = 7;
   localparam int ASYNC_RST_POS   = 1;
   localparam int SYNC_RST_POS    = 0;
   // control a fields
   localparam int COM_A_HI        = 7;
   localparam int COM_A_LO        = 6;
   localparam int COM_B_HI        = 5;
   localparam int COM_B_LO        = 4;
   localparam int WGM_B1_POS      = 1;
   localparam int WGM_B0_POS      = 0;
   // control b fields
   localparam int WGM_B2_POS      = 3;
   localparam int CS_HI           = 2;
   // flag and mask bit positions
   localparam int OVF_POS         = 0;
   localparam int CMPA_POS        = 1;
   localparam int CMPB_POS        = 2;

   localparam logic [7:0] RESET_BYTE  = 8'h00;
   localparam logic [7:0] BOTTOM      = 8'h00;
   localparam logic [7:0] MAX         = 8'hff;

   // prescaler taps: a tap fires when the masked low bits are all ones
   localparam int            PRE_WIDTH   = 10;
   localparam logic [9:0]    PRE_MASK8   = 10'h007;
   localparam logic [9:0]    PRE_MASK64  = 10'h03f;
   localparam logic [9:0]    PRE_MASK256 = 10'h0ff;
   localparam logic [9:0]    PRE_MASK1K  = 10'h3ff;

   // clock select codes
   localparam logic [2:0] CS_STOP   = 3'h0;
   localparam logic [2:0] CS_DIV1   = 3'h1;
   localparam logic [2:0] CS_DIV8   = 3'h2;
   localparam logic [2:0] CS_DIV64  = 3'h3;
   localparam logic [2:0] CS_DIV256 = 3'h4;
   localparam logic [2:0] CS_DIV1K  = 3'h5;
   localparam logic [2:0] CS_EXTFALL= 3'h6;
   localparam logic [2:0] CS_EXTRISE= 3'h7;

   // waveform modes
   localparam logic [2:0] WGM_NORMAL     = 3'h0;
   localparam logic [2:0] WGM_PHASE_MAX  = 3'h1;
   localparam logic [2:0] WGM_CTC        = 3'h2;
   localparam logic [2:0] WGM_FAST_MAX   = 3'h3;
   localparam logic [2:0] WGM_PHASE_OCRA = 3'h5;
   localparam logic [2:0] WGM_FAST_OCRA  = 3'h7;

   // compare output actions
   localparam logic [1:0] COM_NONE   = 2'h0;
   localparam logic [1:0] COM_TOGGLE = 2'h1;
   localparam logic [1:0] COM_CLEAR  = 2'h2;
   localparam logic [1:0] COM_SET    = 2'h3;

   // register bus request carrier
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wrData;
      logic       wrStrobe;
      logic       rdStrobe;
   } tmr8_bus_req_s;

endpackage
`default_nettype wire

// *** sim/tmr8_timer_assertions.sv ***
/*
 * tmr8_timer_checker: port assertions on register reads, interrupt requests
 * and the prescaler reset outputs of the timer.
 * Assumes: bound into tmr8_timer; one clock, async active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module tmr8_timer_checker
(
   input wire logic                    clk_sys,
   input wire logic                    rst_n,
   input wire tmr8_pkg::tmr8_bus_req_s regReq,
   input wire logic [7:0]              rdData,
   input wire logic [2:0]              irqServiced,
   input wire logic [2:0]              irqRequest,
   input wire logic                    syncPrescalerReset,
   input wire logic                    asyncPrescalerReset
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   // decoded strobes per register
   wire logic [7:0] wrD    = regReq.wrData;
   wire logic       wrSync = regReq.wrStrobe && regReq.addr == tmr8_pkg::ADDR_SYNC_CTRL;
   wire logic       wrMask = regReq.wrStrobe && regReq.addr == tmr8_pkg::ADDR_IRQ_MASK;
   wire logic       rdMask = regReq.rdStrobe && regReq.addr == tmr8_pkg::ADDR_IRQ_MASK;
   wire logic       wrCtlA = regReq.wrStrobe && regReq.addr == tmr8_pkg::ADDR_CTRL_A;
   wire logic       rdCtlA = regReq.rdStrobe && regReq.addr == tmr8_pkg::ADDR_CTRL_A;
   wire logic       rdCtlB = regReq.rdStrobe && regReq.addr == tmr8_pkg::ADDR_CTRL_B;

   a_read_idle_zero: assert property (!regReq.rdStrobe |=> rdData == 8'h00)
      else $error("read data not zero outside a read");
   a_mask_readback: assert property (wrMask ##2 rdMask |=> rdData == ($past(wrD, 3) & 8'h07))
      else $error("mask read differs from written value");
   a_ctrla_readback: assert property (wrCtlA ##2 rdCtlA |=> rdData == ($past(wrD, 3) & 8'hf3))
      else $error("control a read differs from written value");
   a_ctrlb_reserved: assert property (rdCtlB |=> rdData[7:4] == 4'h0)
      else $error("control b reserved bits not zero");
   a_mask_zero_quiet: assert property (wrMask && wrD[2:0] == 3'h0 |-> ##2 irqRequest == 3'h0)
      else $error("interrupt request with all masks off");
   a_service_drop: assert property (irqServiced[0] |-> ##2 !irqRequest[0])
      else $error("overflow request stays after service");
   a_hold_keeps_sync: assert property (wrSync && wrD[7] && wrD[0] |-> ##2 syncPrescalerReset[*4])
      else $error("held sync prescaler reset dropped");
   a_hold_keeps_async: assert property (wrSync && wrD[7] && wrD[1] |-> ##2 asyncPrescalerReset[*4])
      else $error("held async prescaler reset dropped");
   a_release_clears: assert property (wrSync && wrD == 8'h00 |-> ##2 !syncPrescalerReset && !asyncPrescalerReset)
      else $error("prescaler resets not cleared on release");
   a_sync_self_clear: assert property (wrSync && !wrD[7] && wrD[0] |-> ##2 syncPrescalerReset ##1 !syncPrescalerReset)
      else $error("sync prescaler reset not a single pulse");

   // main scenarios reached
   c_service: cover property (irqServiced[0]);
   c_hold: cover property (syncPrescalerReset[*4]);
   c_cmpb_irq: cover property ($rose(irqRequest[2]));
endmodule

bind tmr8_timer tmr8_timer_checker u_chk
(
   .clk_sys(clk_sys),
   .rst_n(rst_n),
   .regReq(regReq),
   .rdData(rdData),
   .irqServiced(irqServiced),
   .irqRequest(irqRequest),
   .syncPrescalerReset(syncPrescalerReset),
   .asyncPrescalerReset(asyncPrescalerReset)
);
`default_nettype wire

// *** sim/tmr8_timer_tb_top.sv ***
/*
 * tmr8_timer_tb_top: self-checking bench, register reads and writes,
 * external pin pulses and interrupt service pulses.
 * Assumes: 50 MHz clk_sys; addresses 0 sync, 1/2 ctrl a/b, 3 count,
 * 4/5 compare a/b, 6 mask, 7 flags.
 */
`timescale 1ns/1ps
`default_nettype none
module tmr8_timer_tb_top;
   logic                    clk_sys;
   logic                    rst_n;
   tmr8_pkg::tmr8_bus_req_s regReq;
   logic [7:0]              rdData;
   logic                    externalTimerPin;
   logic [2:0]              irqServiced;
   logic [2:0]              irqRequest;
   logic                    compareOutputA;
   logic                    compareOutputB;
   logic                    syncPrescalerReset;
   logic                    asyncPrescalerReset;
   int                      n_errors;
   int                      comparisons;
   int                      n;
   int                      m;
   int                      i;
   logic [7:0]              v;

   tmr8_timer u_dut
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .regReq(regReq),
      .rdData(rdData),
      .externalTimerPin(externalTimerPin),
      .irqServiced(irqServiced),
      .irqRequest(irqRequest),
      .compareOutputA(compareOutputA),
      .compareOutputB(compareOutputB),
      .syncPrescalerReset(syncPrescalerReset),
      .asyncPrescalerReset(asyncPrescalerReset)
   );

   // 20 ns clock
   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   // run limit
   initial
   begin
      repeat (60000) @(posedge clk_sys);
      n_errors++;
      stop_test();
   end

   task automatic stop_test();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic tick(input int c);
      repeat (c) @(posedge clk_sys);
   endtask

   // one-cycle write strobe, then one idle cycle
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      regReq <= {a, d, 1'b1, 1'b0};
      tick(1);
      regReq <= {a, 8'h00, 1'b0, 1'b0};
      tick(1);
   endtask

   // read data taken in the cycle after the strobe
   task automatic rd(input logic [2:0] a);
      regReq <= {a, 8'h00, 1'b0, 1'b1};
      tick(1);
      regReq <= {a, 8'h00, 1'b0, 1'b0};
      #1 v = rdData;
      tick(1);
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
      rd(a);
      chk(v, exp);
   endtask

   // bounded wait for one interrupt request bit
   task automatic waitIrq(input int b, input int lim);
      for (n = 0; n < lim && irqRequest[b] !== 1'b1; n++)
         tick(1);
      if (n == lim)
      begin
         n_errors++;
         $display("[FAIL] %0t interrupt wait timed out", $time);
         stop_test();
      end
   endtask

   task automatic pulse(input int c);
      repeat (c)
      begin
         externalTimerPin <= 1'b1;
         tick(4);
         externalTimerPin <= 1'b0;
         tick(4);
      end
   endtask

   // main sequence
   initial
   begin
      n_errors = 0;
      comparisons = 0;
      rst_n = 1'b0;
      regReq = '0;
      externalTimerPin = 1'b0;
      irqServiced = 3'h0;
      tick(5);
      rst_n <= 1'b1;
      tick(1);
      for (i = 0; i < 8; i++)
         rdchk(3'(i), 8'h00);
      // reserved bits and stopped counter
      wr(3'h6, 8'hff);
      rdchk(3'h6, 8'h07);
      wr(3'h1, 8'hff);
      rdchk(3'h1, 8'hf3);
      wr(3'h1, 8'h00);
      wr(3'h2, 8'hf0);
      rdchk(3'h2, 8'h00);
      wr(3'h3, 8'h5a);
      tick(20);
      rdchk(3'h3, 8'h5a);
      wr(3'h4, 8'h03);
      rdchk(3'h4, 8'h03);
      wr(3'h5, 8'h02);
      rdchk(3'h5, 8'h02);
      // sync hold, release and self-clearing reset bit
      wr(3'h0, 8'h83);
      tick(4);
      rdchk(3'h0, 8'h83);
      chk({6'h00, syncPrescalerReset, asyncPrescalerReset}, 8'h03);
      wr(3'h0, 8'h00);
      rdchk(3'h0, 8'h00);
      wr(3'h0, 8'h01);
      tick(3);
      rdchk(3'h0, 8'h00);
      // held prescaler stops a divide-by-8 count
      wr(3'h0, 8'h81);
      wr(3'h3, 8'h00);
      wr(3'h2, 8'h02);
      tick(40);
      rdchk(3'h3, 8'h00);
      wr(3'h0, 8'h00);
      tick(78);
      rd(3'h3);
      chk({7'h00, v >= 8'h09 && v <= 8'h0b}, 8'h01);
      // normal mode overflow, clearing and masking
      wr(3'h2, 8'h00);
      wr(3'h6, 8'h01);
      wr(3'h3, 8'hf0);
      wr(3'h7, 8'h07);
      wr(3'h2, 8'h01);
      waitIrq(0, 40);
      chk({7'h00, n >= 14 && n <= 20}, 8'h01);
      rd(3'h7);
      chk({7'h00, v[0]}, 8'h01);
      wr(3'h7, 8'h00);
      rd(3'h7);
      chk({7'h00, v[0]}, 8'h01);
      wr(3'h7, 8'h01);
      rd(3'h7);
      chk({7'h00, v[0]}, 8'h00);
      waitIrq(0, 300);
      irqServiced <= 3'h1;
      tick(1);
      irqServiced <= 3'h0;
      tick(3);
      chk({5'h00, irqRequest}, 8'h00);
      wr(3'h6, 8'h00);
      tick(300);
      chk({5'h00, irqRequest}, 8'h00);
      rd(3'h7);
      chk({7'h00, v[0]}, 8'h01);
      wr(3'h3, 8'h10);
      rd(3'h3);
      chk({7'h00, v >= 8'h10 && v <= 8'h13}, 8'h01);
      // clear on match with toggling output a
      wr(3'h2, 8'h00);
      wr(3'h3, 8'h00);
      wr(3'h7, 8'h07);
      wr(3'h1, 8'h52);
      wr(3'h2, 8'h01);
      for (i = 0; i < 12; i++)
      begin
         rd(3'h3);
         chk({7'h00, v <= 8'h03}, 8'h01);
      end
      n = 0;
      m = 0;
      for (i = 0; i < 16; i++)
      begin
         v[1:0] = {compareOutputB, compareOutputA};
         tick(1);
         if (compareOutputA !== v[0])
            n++;
         if (compareOutputB !== v[1])
            m++;
      end
      chk(8'(n), 8'h04);
      chk(8'(m), 8'h04);
      rdchk(3'h7, 8'h06);
      // fast pwm: compare b loads only at top
      wr(3'h2, 8'h00);
      wr(3'h1, 8'h03);
      wr(3'h3, 8'h10);
      wr(3'h5, 8'h12);
      wr(3'h7, 8'h07);
      wr(3'h6, 8'h04);
      wr(3'h2, 8'h01);
      waitIrq(2, 400);
      chk({7'h00, n >= 200}, 8'h01);
      rdchk(3'h5, 8'h12);
      // external pin rising then falling edges
      wr(3'h2, 8'h00);
      wr(3'h1, 8'h00);
      wr(3'h3, 8'h00);
      wr(3'h2, 8'h07);
      pulse(5);
      tick(6);
      rdchk(3'h3, 8'h05);
      wr(3'h2, 8'h06);
      pulse(3);
      tick(6);
      rdchk(3'h3, 8'h08);
      // phase correct: count turns down at max
      wr(3'h2, 8'h00);
      wr(3'h1, 8'h01);
      wr(3'h3, 8'hfe);
      wr(3'h2, 8'h01);
      rdchk(3'h3, 8'hff);
      rdchk(3'h3, 8'hfd);
      stop_test();
   end
endmodule
`default_nettype wire
